// ==== verilog/atsp_pkg.sv ====
// shared constants, channel structs and state codes for the tcm slave port
package atsp_pkg;
  localparam int DATA_W = 64;
  localparam int STRB_W = 8;
  localparam int ADDR_W = 32;
  localparam int LEN_W = 4;
  localparam int MEM_IDX_W = 20;
  localparam int NUM_MEM = 4;

  localparam logic [2:0] SIZE_BYTE = 3'h0;
  localparam logic [2:0] SIZE_HALF = 3'h1;
  localparam logic [2:0] SIZE_WORD = 3'h2;
  localparam logic [2:0] SIZE_DWORD = 3'h3;

  localparam logic [1:0] BURST_FIXED = 2'h0;
  localparam logic [1:0] BURST_INCR = 2'h1;
  localparam logic [1:0] BURST_WRAP = 2'h2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // memory select: bit 0 picks data memory, bit 1 picks processor 1
  localparam logic [1:0] SEL_INSTR0 = 2'h0;
  localparam logic [1:0] SEL_DATA0 = 2'h1;
  localparam logic [1:0] SEL_INSTR1 = 2'h2;
  localparam logic [1:0] SEL_DATA1 = 2'h3;
  localparam int SEL_DATA_BIT = 0;
  localparam int SEL_CPU1_BIT = 1;

  localparam logic [7:0] STRB_ALL = 8'hFF;
  localparam logic [7:0] STRB_LO = 8'h0F;
  localparam logic [7:0] STRB_HI = 8'hF0;
  localparam logic [7:0] STRB_HALF = 8'h03;
  localparam logic [7:0] STRB_BYTE = 8'h01;

  // memory write enables per 32-bit half of the doubleword
  localparam logic [1:0] WE_NONE = 2'h0;
  localparam logic [1:0] WE_LO = 2'h1;
  localparam logic [1:0] WE_HI = 2'h2;
  localparam logic [1:0] WE_BOTH = 2'h3;

  localparam logic [ADDR_W-1:0] ADDR_STEP = 32'h0000_0008;
  localparam logic [1:0] RST_SYNC_INIT = 2'h0;
  localparam logic [LEN_W-1:0] BEAT_INIT = 4'h0;

  typedef struct packed {
    logic [ADDR_W-1:0] slave_address;
    logic [LEN_W-1:0] slave_burst_length;
    logic [2:0] slave_transfer_size;
    logic [1:0] slave_burst_type;
    logic [1:0] memory_select_sideband;
  } atsp_ax_s;

  typedef struct packed {
    logic [1:0] we;
    logic [MEM_IDX_W-1:0] idx;
    logic [DATA_W-1:0] wdata;
  } atsp_mreq_s;

  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_RADDR = 9'h002,
    ST_RCAP = 9'h004,
    ST_RSEND = 9'h008,
    ST_WDATA = 9'h010,
    ST_WRD = 9'h020,
    ST_WCAP = 9'h040,
    ST_WWRITE = 9'h080,
    ST_BRESP = 9'h100
  } atsp_state_e;
endpackage

// ==== verilog/atsp_check.sv ====
// legality check of one address-channel request
`timescale 1ns/1ps
module atsp_check import atsp_pkg::*; #(
  parameter int ILM_AW = 16,
  parameter int DLM_AW = 16,
  parameter bit CPU1_PRESENT = 1'b1
) (
  input wire atsp_ax_s ax,
  output logic err
);
  logic form_ok;
  logic range_ok;
  logic cpu_ok;
  logic [ADDR_W:0] end_addr;

  always_comb begin
    end_addr = {1'b0, ax.slave_address};
    // an incrementing burst must end inside the memory too
    if (ax.slave_burst_type == BURST_INCR) begin
      end_addr = {1'b0, ax.slave_address} + {{(ADDR_W-LEN_W-2){1'b0}}, ax.slave_burst_length, 3'h0};
    end
    form_ok = (ax.slave_transfer_size == SIZE_DWORD && ax.slave_address[2:0] == 3'h0) ||
              (ax.slave_burst_length == BEAT_INIT &&
               ((ax.slave_transfer_size == SIZE_WORD && ax.slave_address[1:0] == 2'h0) ||
                (ax.slave_transfer_size == SIZE_HALF && !ax.slave_address[0]) ||
                ax.slave_transfer_size == SIZE_BYTE));
    range_ok = ax.memory_select_sideband[SEL_DATA_BIT] ? ((end_addr >> DLM_AW) == '0)
                                                       : ((end_addr >> ILM_AW) == '0);
    cpu_ok = !ax.memory_select_sideband[SEL_CPU1_BIT] || CPU1_PRESENT;
    err = !(form_ok && range_ok && cpu_ok);
  end
endmodule

// ==== verilog/atsp_merge.sv ====
// byte-lane merge of new write data over old memory data
`timescale 1ns/1ps
module atsp_merge import atsp_pkg::*; #(
  parameter int W = DATA_W
) (
  input wire logic [W-1:0] old_data,
  input wire logic [W-1:0] new_data,
  input wire logic [W/8-1:0] be,
  output logic [W-1:0] merged
);
  genvar i;
  generate
    for (i = 0; i < W/8; i++) begin : g_lane
      assign merged[8*i+7:8*i] = be[i] ? new_data[8*i+7:8*i] : old_data[8*i+7:8*i];
    end
  endgenerate
endmodule

// ==== verilog/atsp_slave_port.sv ====
// axi slave port into the four local instruction and data memories
// How it works
// - select sideband picks one of four memories
// - core traffic wins over slave port
// - no protection-unit checks on slave accesses
// - 64-bit data, standard axi handshakes
// - id width is a parameter, one minimum
// - aligned doubleword, any length and burst type
// - single aligned word, burst type ignored
// - single aligned halfword, burst type ignored
// - single byte at any address
// - anything else answers slave error
// - partial writes complete through read-modify-write, except whole aligned words to data memory
// - beyond memory size answers slave error
// - processor 1 absent answers slave error
// - no lock, cache or protection inputs
// - exclusive read answers okay, no monitor
`timescale 1ns/1ps
module atsp_slave_port import atsp_pkg::*; #(
  parameter int ID_W = 4,
  parameter int ILM_AW = 16,
  parameter int DLM_AW = 16,
  parameter bit CPU1_PRESENT = 1'b1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic awvalid,
  output logic awready,
  input wire atsp_ax_s s_aw,
  input wire logic [ID_W-1:0] awid,
  input wire logic wvalid,
  output logic wready,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [STRB_W-1:0] slave_write_strobes,
  input wire logic wlast,
  output logic bvalid,
  input wire logic bready,
  output logic [ID_W-1:0] bid,
  output logic [1:0] b_slave_response,
  input wire logic arvalid,
  output logic arready,
  input wire atsp_ax_s s_ar,
  input wire logic [ID_W-1:0] arid,
  output logic rvalid,
  input wire logic rready,
  output logic [ID_W-1:0] rid,
  output logic [DATA_W-1:0] rdata,
  output logic [1:0] r_slave_response,
  output logic rlast,
  input wire logic [NUM_MEM-1:0] core_busy,
  output logic [NUM_MEM-1:0] mem_en,
  output atsp_mreq_s mem_req,
  input wire logic [NUM_MEM-1:0][DATA_W-1:0] mem_rdata
);
  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic rst_n_s;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_q <= RST_SYNC_INIT;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n_s = rst_sync_q[1];

  // ----------------------------------------------------------------
  // request checks and arbitration
  // ----------------------------------------------------------------
  atsp_state_e state_q, state_d;
  atsp_ax_s ax_q;
  logic [ID_W-1:0] id_q;
  logic [LEN_W-1:0] beat_q;
  logic [DATA_W-1:0] wdata_q, rdata_q, merged;
  logic [STRB_W-1:0] be_q, be_d;
  logic [1:0] we_q, we_d;
  logic err_q, rr_q, last_q;
  logic aw_err, ar_err, take_wr, take_rd, mem_go, r_done, w_beat;

  atsp_check #(.ILM_AW(ILM_AW), .DLM_AW(DLM_AW), .CPU1_PRESENT(CPU1_PRESENT)) u_aw_check (
    .ax(s_aw),
    .err(aw_err)
  );
  atsp_check #(.ILM_AW(ILM_AW), .DLM_AW(DLM_AW), .CPU1_PRESENT(CPU1_PRESENT)) u_ar_check (
    .ax(s_ar),
    .err(ar_err)
  );
  // old data is merged in the capture cycle itself, while the memory still shows it
  atsp_merge #(.W(DATA_W)) u_merge (
    .old_data(mem_rdata[ax_q.memory_select_sideband]),
    .new_data(wdata_q),
    .be(be_q),
    .merged(merged)
  );

  // reads and writes alternate when both wait, so neither starves
  assign take_wr = ce && state_q == ST_IDLE && awvalid && (!arvalid || !rr_q);
  assign take_rd = ce && state_q == ST_IDLE && arvalid && !take_wr;
  assign awready = take_wr;
  assign arready = take_rd;

  // ----------------------------------------------------------------
  // axi response side
  // ----------------------------------------------------------------
  assign wready = ce && state_q == ST_WDATA;
  assign w_beat = wready && wvalid;
  assign rvalid = state_q == ST_RSEND;
  assign rlast = beat_q == ax_q.slave_burst_length;
  assign r_done = ce && rvalid && rready;
  assign rid = id_q;
  assign rdata = rdata_q;
  // no lock input exists, so an exclusive read is just a read
  assign r_slave_response = err_q ? RESP_SLVERR : RESP_OKAY;
  assign bvalid = state_q == ST_BRESP;
  assign bid = id_q;
  assign b_slave_response = err_q ? RESP_SLVERR : RESP_OKAY;

  // ----------------------------------------------------------------
  // memory side
  // ----------------------------------------------------------------
  // no permission check sits on this path
  assign mem_go = ce && (state_q == ST_RADDR || state_q == ST_WRD || state_q == ST_WWRITE) &&
                  !core_busy[ax_q.memory_select_sideband];

  always_comb begin
    mem_en = '0;
    mem_en[ax_q.memory_select_sideband] = mem_go;
  end

  assign mem_req = '{we: (mem_go && state_q == ST_WWRITE) ? we_q : WE_NONE,
                     idx: ax_q.slave_address[MEM_IDX_W+2:3],
                     wdata: wdata_q};

  function automatic logic [STRB_W-1:0] lane_mask(input logic [2:0] sz, input logic [2:0] a);
    case (sz)
      SIZE_DWORD: lane_mask = STRB_ALL;
      SIZE_WORD: lane_mask = a[2] ? STRB_HI : STRB_LO;
      SIZE_HALF: lane_mask = STRB_HALF << {a[2:1], 1'b0};
      default: lane_mask = STRB_BYTE << a;
    endcase
  endfunction

  function automatic logic [ADDR_W-1:0] next_addr(input atsp_ax_s ax);
    logic [ADDR_W-1:0] inc;
    logic [ADDR_W-1:0] mask;
    inc = ax.slave_address + ADDR_STEP;
    mask = {{(ADDR_W-LEN_W-3){1'b0}}, ax.slave_burst_length, 3'h7};
    case (ax.slave_burst_type)
      BURST_FIXED: next_addr = ax.slave_address;
      BURST_WRAP: next_addr = (ax.slave_address & ~mask) | (inc & mask);
      default: next_addr = inc;
    endcase
  endfunction

  // only full doublewords and data-memory word halves go straight in
  always_comb begin
    be_d = slave_write_strobes & lane_mask(ax_q.slave_transfer_size, ax_q.slave_address[2:0]);
    we_d = WE_NONE;
    if (ax_q.slave_transfer_size == SIZE_DWORD && be_d == STRB_ALL) begin
      we_d = WE_BOTH;
    end else if (ax_q.slave_transfer_size == SIZE_WORD && ax_q.memory_select_sideband[SEL_DATA_BIT]) begin
      if (be_d == STRB_LO) begin
        we_d = WE_LO;
      end else if (be_d == STRB_HI) begin
        we_d = WE_HI;
      end
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (take_wr) begin
          state_d = ST_WDATA;
        end else if (take_rd) begin
          state_d = ar_err ? ST_RSEND : ST_RADDR;
        end
      end
      ST_RADDR: begin
        if (mem_go) begin
          state_d = ST_RCAP;
        end
      end
      ST_RCAP: state_d = ST_RSEND;
      ST_RSEND: begin
        if (r_done) begin
          state_d = rlast ? ST_IDLE : (err_q ? ST_RSEND : ST_RADDR);
        end
      end
      ST_WDATA: begin
        if (w_beat) begin
          if (err_q) begin
            state_d = wlast ? ST_BRESP : ST_WDATA;
          end else begin
            state_d = (we_d == WE_NONE) ? ST_WRD : ST_WWRITE;
          end
        end
      end
      ST_WRD: begin
        if (mem_go) begin
          state_d = ST_WCAP;
        end
      end
      ST_WCAP: state_d = ST_WWRITE;
      ST_WWRITE: begin
        if (mem_go) begin
          state_d = last_q ? ST_BRESP : ST_WDATA;
        end
      end
      ST_BRESP: begin
        if (ce && bready) begin
          state_d = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      state_q <= ST_IDLE;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // transfer context
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      ax_q <= '0;
      id_q <= '0;
      err_q <= 1'b0;
      rr_q <= 1'b0;
      beat_q <= BEAT_INIT;
    end else if (ce) begin
      if (take_wr || take_rd) begin
        ax_q <= take_wr ? s_aw : s_ar;
        id_q <= take_wr ? awid : arid;
        err_q <= take_wr ? aw_err : ar_err;
        rr_q <= take_wr;
        beat_q <= BEAT_INIT;
      end else if (r_done && !rlast) begin
        beat_q <= beat_q + 4'h1;
        ax_q.slave_address <= next_addr(ax_q);
      end else if (mem_go && state_q == ST_WWRITE && !last_q) begin
        ax_q.slave_address <= next_addr(ax_q);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      wdata_q <= '0;
      be_q <= '0;
      we_q <= WE_NONE;
      last_q <= 1'b0;
    end else if (ce) begin
      if (w_beat && !err_q) begin
        wdata_q <= wdata;
        be_q <= be_d;
        we_q <= we_d;
        last_q <= wlast;
      end else if (state_q == ST_WCAP) begin
        // slow path: old doubleword with the strobed lanes replaced
        wdata_q <= merged;
        we_q <= WE_BOTH;
      end
    end
  end

  // memory data is valid one cycle after the read enable
  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      rdata_q <= '0;
    end else if (ce) begin
      if (take_rd) begin
        rdata_q <= '0;
      end else if (state_q == ST_RCAP || state_q == ST_WCAP) begin
        rdata_q <= mem_rdata[ax_q.memory_select_sideband];
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_core_has_priority:
    assert property (@(posedge clk) disable iff (!rst_n_s) (mem_en & core_busy) == 4'h0)
    else $error("slave port used a memory the core is busy with");
  a_route_by_select:
    assert property (@(posedge clk) disable iff (!rst_n_s)
      (mem_en != 4'h0) |-> (mem_en == (4'h1 << ax_q.memory_select_sideband)))
    else $error("memory enable does not follow the select sideband");
  a_narrow_burst_err:
    assert property (@(posedge clk) disable iff (!rst_n_s)
      (awvalid && awready && s_aw.slave_transfer_size != SIZE_DWORD && s_aw.slave_burst_length != 4'h0)
      |=> err_q)
    else $error("narrow burst not flagged as error");
  a_cpu1_absent:
    assert property (@(posedge clk) disable iff (!rst_n_s)
      (arvalid && arready && s_ar.memory_select_sideband[SEL_CPU1_BIT] && !CPU1_PRESENT)
      |=> rvalid && r_slave_response == RESP_SLVERR)
    else $error("access to absent processor 1 not refused");
  a_range_err:
    assert property (@(posedge clk) disable iff (!rst_n_s)
      (arvalid && arready && s_ar.memory_select_sideband == SEL_DATA0 && (s_ar.slave_address >> DLM_AW) != 0)
      |=> rvalid && r_slave_response == RESP_SLVERR)
    else $error("out of range read not refused");
  a_byte_ok:
    assert property (@(posedge clk) disable iff (!rst_n_s)
      (arvalid && arready && s_ar.slave_transfer_size == SIZE_BYTE && s_ar.slave_burst_length == 4'h0 &&
       s_ar.memory_select_sideband == SEL_INSTR0 && (s_ar.slave_address >> ILM_AW) == 0) |=> !err_q && !rvalid)
    else $error("legal byte read refused");
  a_dword_ok:
    assert property (@(posedge clk) disable iff (!rst_n_s)
      (awvalid && awready && s_aw.slave_transfer_size == SIZE_DWORD && s_aw.slave_address[2:0] == 3'h0 &&
       s_aw.slave_burst_type != BURST_INCR && s_aw.memory_select_sideband == SEL_INSTR0 &&
       (s_aw.slave_address >> ILM_AW) == 0) |=> !err_q)
    else $error("legal doubleword write refused");
  a_err_write_dropped:
    assert property (@(posedge clk) disable iff (!rst_n_s) (err_q && state_q != ST_IDLE) |-> mem_en == 4'h0)
    else $error("erroring transfer reached a memory");
  a_r_held:
    assert property (@(posedge clk) disable iff (!rst_n_s)
      (rvalid && !rready) |=> rvalid && $stable(rdata) && $stable(rlast) && $stable(r_slave_response))
    else $error("read beat changed before acceptance");
endmodule

// ==== test/atsp_master_model.sv ====
// axi master model that drives the tcm slave port
`timescale 1ns/1ps
module atsp_master_model import atsp_pkg::*; (
  input wire logic clk,
  output logic awvalid,
  input wire logic awready,
  output atsp_ax_s s_aw,
  output logic [3:0] awid,
  output logic wvalid,
  input wire logic wready,
  output logic [DATA_W-1:0] wdata,
  output logic [STRB_W-1:0] slave_write_strobes,
  output logic wlast,
  input wire logic bvalid,
  output logic bready,
  input wire logic [1:0] b_slave_response,
  output logic arvalid,
  input wire logic arready,
  output atsp_ax_s s_ar,
  output logic [3:0] arid,
  input wire logic rvalid,
  output logic rready,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic [1:0] r_slave_response,
  input wire logic rlast
);
  // slow: gaps between write beats and a toggling read ready
  bit slow = 1'h0;

  initial begin
    {awvalid, wvalid, wlast, bready, arvalid, rready} = 6'h0;
    {s_aw, s_ar, awid, arid, wdata, slave_write_strobes} = '0;
  end

  // released lines show the inverse so stale values are never mistaken for live ones
  task automatic write_burst(input atsp_ax_s a, input logic [63:0] d[$], input logic [7:0] s,
                             output logic [1:0] resp);
    awvalid <= 1'h1;
    s_aw <= a;
    awid <= 4'h5;
    repeat (64) begin @(posedge clk); if (awready) break; end
    awvalid <= 1'h0;
    s_aw <= ~a;
    foreach (d[i]) begin
      wvalid <= 1'h1;
      wdata <= d[i];
      slave_write_strobes <= s;
      wlast <= (i == d.size() - 1);
      repeat (64) begin @(posedge clk); if (wready) break; end
      if (slow || i == d.size() - 1) begin
        wdata <= ~d[i];
        wvalid <= 1'h0;
        @(posedge clk);
      end
    end
    bready <= 1'h1;
    repeat (64) begin @(posedge clk); if (bvalid) break; end
    resp = b_slave_response;
    bready <= 1'h0;
  endtask

  // no lock signal exists, so an exclusive read is a plain read and no store follows it
  task automatic read_burst(input atsp_ax_s a, output logic [63:0] d[$], output logic [1:0] r[$],
                            output logic l[$]);
    d = {};
    r = {};
    l = {};
    arvalid <= 1'h1;
    s_ar <= a;
    arid <= 4'hA;
    repeat (64) begin @(posedge clk); if (arready) break; end
    arvalid <= 1'h0;
    s_ar <= ~a;
    rready <= 1'h1;
    repeat (400) begin
      @(posedge clk);
      if (rvalid && rready) begin
        d.push_back(rdata);
        r.push_back(r_slave_response);
        l.push_back(rlast);
        if (rlast) break;
      end
      if (slow) rready <= ~rready;
    end
    rready <= 1'h0;
  endtask
endmodule

// ==== test/test_atsp_slave_port.sv ====
// self-checking bench for the tcm slave port
`timescale 1ns/1ps
module test_atsp_slave_port import atsp_pkg::*;;
  logic clk, reset_n, awvalid, awready, wvalid, wready, wlast, bvalid, bready;
  logic arvalid, arready, rvalid, rready, rlast;
  atsp_ax_s s_aw, s_ar;
  logic [3:0] awid, arid, core_busy, mem_en, bid, rid;
  logic [63:0] wdata, rdata, tmp;
  logic [7:0] strb;
  logic [1:0] bresp, rresp, rs;
  atsp_mreq_s mem_req;
  logic [NUM_MEM-1:0][DATA_W-1:0] rd_q;
  logic [63:0] mem [4][bit [19:0]];
  logic [63:0] dq[$];
  logic [1:0] rq[$];
  logic lq[$];
  int err_count = 0;
  int samples_checked = 0;

  atsp_slave_port i_dut (.clk(clk), .reset_n(reset_n), .ce(1'h1), .awvalid(awvalid), .awready(awready),
    .s_aw(s_aw), .awid(awid), .wvalid(wvalid), .wready(wready), .wdata(wdata), .slave_write_strobes(strb),
    .wlast(wlast), .bvalid(bvalid), .bready(bready), .bid(bid), .b_slave_response(bresp), .arvalid(arvalid),
    .arready(arready), .s_ar(s_ar), .arid(arid), .rvalid(rvalid), .rready(rready), .rid(rid), .rdata(rdata),
    .r_slave_response(rresp), .rlast(rlast), .core_busy(core_busy), .mem_en(mem_en), .mem_req(mem_req),
    .mem_rdata(rd_q));
  atsp_master_model i_master (.clk(clk), .awvalid(awvalid), .awready(awready), .s_aw(s_aw), .awid(awid),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .slave_write_strobes(strb), .wlast(wlast),
    .bvalid(bvalid), .bready(bready), .b_slave_response(bresp), .arvalid(arvalid), .arready(arready),
    .s_ar(s_ar), .arid(arid), .rvalid(rvalid), .rready(rready), .rdata(rdata), .r_slave_response(rresp),
    .rlast(rlast));

  // ----------------------------------------
  // memory arrays, one-cycle read latency
  // ----------------------------------------
  function automatic logic [63:0] peek(int s, bit [19:0] i);
    return mem[s].exists(i) ? mem[s][i] : 64'h0;
  endfunction

  // read data is scrambled once its one cycle has passed
  always @(posedge clk) begin
    for (int s = 0; s < 4; s++) begin
      rd_q[s] <= ~rd_q[s];
      if (mem_en[s]) begin
        tmp = peek(s, mem_req.idx);
        if (mem_req.we == WE_NONE) rd_q[s] <= tmp;
        if (mem_req.we[0]) tmp[31:0] = mem_req.wdata[31:0];
        if (mem_req.we[1]) tmp[63:32] = mem_req.wdata[63:32];
        if (mem_req.we != WE_NONE) mem[s][mem_req.idx] = tmp;
      end
    end
  end

  always @(posedge clk) if (reset_n) chk_data(64'(mem_en & core_busy), 64'h0);

  // ----------------------------------------
  // compares and helpers
  // ----------------------------------------
  task automatic chk_data(input logic [63:0] g, input logic [63:0] e);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
    chk_data(64'(g), 64'(e));
  endtask

  function automatic atsp_ax_s ax(logic [31:0] a, int n, logic [2:0] z, logic [1:0] b, int s);
    return '{a, 4'(n), z, b, 2'(s)};
  endfunction

  task automatic final_report;
    if (err_count == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_select;
    for (int s = 0; s < 4; s++) begin
      i_master.write_burst(ax(32'h100, 0, SIZE_DWORD, BURST_INCR, s), {64'hC0DE_0000_0000_0000 | 64'(s)}, STRB_ALL, rs);
      chk_resp(rs, RESP_OKAY);
      chk_data(64'(bid), 64'h5);
    end
    for (int s = 0; s < 4; s++) begin
      chk_data(peek(s, 20'h20), 64'hC0DE_0000_0000_0000 | 64'(s));
      i_master.read_burst(ax(32'h100, 0, SIZE_DWORD, BURST_FIXED, s), dq, rq, lq);
      chk_data(dq[0], 64'hC0DE_0000_0000_0000 | 64'(s));
      chk_resp(rq[0], RESP_OKAY);
      chk_data(64'(rid), 64'hA);
    end
  endtask

  task automatic t_burst;
    i_master.slow = 1'h1;
    i_master.write_burst(ax(32'h200, 3, SIZE_DWORD, BURST_INCR, 1), {64'hB0, 64'hB1, 64'hB2, 64'hB3}, STRB_ALL, rs);
    chk_resp(rs, RESP_OKAY);
    i_master.read_burst(ax(32'h210, 3, SIZE_DWORD, BURST_WRAP, 1), dq, rq, lq);
    chk_data(64'(dq.size()), 64'h4);
    foreach (dq[i]) chk_data(dq[i], 64'hB0 + 64'((i + 2) % 4));
    i_master.read_burst(ax(32'h208, 1, SIZE_DWORD, BURST_FIXED, 1), dq, rq, lq);
    foreach (dq[i]) chk_data(dq[i], 64'hB1);
    i_master.slow = 1'h0;
  endtask

  task automatic t_narrow;
    logic [31:0] ad[4] = '{32'h304, 32'h302, 32'h301, 32'h300};
    logic [2:0] sz[4] = '{SIZE_WORD, SIZE_HALF, SIZE_BYTE, SIZE_DWORD};
    logic [7:0] sb[4] = '{8'hF0, 8'h0C, 8'h02, 8'h81};
    logic [63:0] dv[4] = '{64'hAAAA_AAAA_0000_0000, 64'hBBBB_0000, 64'hCC00, 64'hDD00_0000_0000_00EE};
    i_master.write_burst(ax(32'h300, 0, SIZE_DWORD, BURST_INCR, 0), {64'h0011_2233_4455_6677}, STRB_ALL, rs);
    for (int k = 0; k < 4; k++) begin
      i_master.write_burst(ax(ad[k], 0, sz[k], 2'(k), 0), {dv[k]}, sb[k], rs);
      chk_resp(rs, RESP_OKAY);
    end
    i_master.read_burst(ax(32'h300, 0, SIZE_DWORD, BURST_INCR, 0), dq, rq, lq);
    chk_data(dq[0], 64'hDDAA_AAAA_BBBB_CCEE);
    i_master.read_burst(ax(32'h301, 0, SIZE_BYTE, BURST_WRAP, 0), dq, rq, lq);
    chk_data(64'(dq[0][15:8]), 64'hCC);
    i_master.write_burst(ax(32'h21C, 0, SIZE_WORD, BURST_INCR, 1), {64'h1234_5678_0000_0000}, STRB_HI, rs);
    chk_resp(rs, RESP_OKAY);
    chk_data(peek(1, 20'h43), 64'h1234_5678_0000_00B3);
  endtask

  task automatic t_errors;
    atsp_ax_s bad[7];
    bad = '{ax(32'h404, 0, SIZE_DWORD, BURST_INCR, 1), ax(32'h400, 1, SIZE_WORD, BURST_INCR, 1),
            ax(32'h401, 0, SIZE_HALF, BURST_INCR, 1), ax(32'h402, 0, SIZE_WORD, BURST_INCR, 1),
            ax(32'h10000, 0, SIZE_DWORD, BURST_INCR, 1), ax(32'hFFF8, 1, SIZE_DWORD, BURST_INCR, 1),
            ax(32'h400, 0, 3'h4, BURST_INCR, 1)};
    foreach (bad[k]) begin
      i_master.read_burst(bad[k], dq, rq, lq);
      chk_data(64'(dq.size()), 64'(bad[k].slave_burst_length) + 64'h1);
      foreach (rq[i]) begin
        chk_resp(rq[i], RESP_SLVERR);
        chk_data(64'(lq[i]), 64'(i == rq.size() - 1));
      end
    end
    i_master.write_burst(ax(32'h304, 0, SIZE_DWORD, BURST_INCR, 0), {64'h0}, STRB_ALL, rs);
    chk_resp(rs, RESP_SLVERR);
    i_master.write_burst(ax(32'h300, 1, SIZE_HALF, BURST_INCR, 0), {64'h0, 64'h0}, STRB_HALF, rs);
    chk_resp(rs, RESP_SLVERR);
    chk_data(peek(0, 20'h60), 64'hDDAA_AAAA_BBBB_CCEE);
  endtask

  task automatic t_contend;
    core_busy <= 4'h2;
    fork
      i_master.read_burst(ax(32'h100, 0, SIZE_DWORD, BURST_INCR, 1), dq, rq, lq);
      begin
        repeat (12) begin
          @(posedge clk);
          chk_data(64'(rvalid), 64'h0);
        end
        core_busy <= 4'h0;
      end
    join
    chk_data(dq[0], 64'hC0DE_0000_0000_0001);
  endtask

  // ----------------------------------------
  // clock, reset, sequence, watchdog
  // ----------------------------------------
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    reset_n = 1'h0;
    core_busy = 4'h0;
    rd_q = '0;
    repeat (8) @(posedge clk);
    reset_n <= 1'h1;
    repeat (3) @(posedge clk);
    t_select;
    t_burst;
    t_narrow;
    t_errors;
    t_contend;
    final_report;
  end

  // the whole sequence needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    final_report;
  end
endmodule
